// ===== include/fppi_pkg.sv
// Package with constants, types and carriers of the flash pin and protect block
package fppi_pkg;

  // ****************************************************************
  // Sizes and layout
  // ****************************************************************
  localparam int ID_W       = 4;        // Identity strap width
  localparam int GPI_W      = 5;        // Board input width
  localparam int ADDR_W     = 20;       // Full address width
  localparam int ROW_W      = 11;       // Row half, bits 0..10
  localparam int COL_W      = 9;        // Column half, bits 11..19
  localparam int COL_LSB    = 11;       // First column bit
  localparam int DATA_W     = 8;        // Data pin width
  localparam int NIB_W      = 4;        // Hub nibble width
  localparam int BLK_W      = 4;        // Block index width
  localparam int NBLK       = 16;       // Lock bits held
  localparam int BLK_LSB    = 16;       // Block index field in address
  localparam int STAT_READY = 7;        // Status bit mirrored on ready pin in mux mode
  localparam int STAT_DENY  = 4;        // Status bit set by a refused alter

  // ****************************************************************
  // Top block for each density
  // ****************************************************************
  localparam logic [BLK_W-1:0] TOP_BLK_4M = 4'h7;  // 4 Mbit part
  localparam logic [BLK_W-1:0] TOP_BLK_8M = 4'hf;  // 8 Mbit part

  // ****************************************************************
  // Register offsets of the local register port
  // ****************************************************************
  localparam logic [3:0] OFS_IDENT  = 4'h0;  // Identity strap, read only
  localparam logic [3:0] OFS_GPI    = 4'h1;  // Board inputs, read only
  localparam logic [3:0] OFS_LOCK   = 4'h2;  // Write lock bits, read write
  localparam logic [3:0] OFS_STATUS = 4'h3;  // Status byte, read only
  localparam logic [3:0] OFS_REQ    = 4'h4;  // Alter request, write only
  localparam logic [3:0] OFS_DONE   = 4'h5;  // Finish alter, write only
  localparam logic [3:0] OFS_MUX    = 4'h6;  // Latched mux write-seen flag and address bits 19..8
  localparam logic [3:0] OFS_MUXD   = 4'h7;  // Latched mux address bits 7..0 and data byte

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NBLK-1:0]   LOCK_RST = 16'hffff;  // All blocks locked
  localparam logic [DATA_W-1:0] STAT_RST = 8'h80;     // Ready, no errors

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    FPPI_IDLE,
    FPPI_BUSY,
    FPPI_FAIL
  } fppi_op_e;

  // Alter request from the command front end
  typedef struct packed {
    logic              valid;  // One-cycle request
    logic [BLK_W-1:0]  blk;    // Target block
  } fppi_req_s;

  // Multiplexed pin group
  typedef struct packed {
    logic [ROW_W-1:0]  addr;   // Shared address pins
    logic              row_sel; // Row/column select, high = row
    logic              wr_n;   // Write strobe, low active
    logic              oe_n;   // Output gate, low active
  } fppi_mux_s;

endpackage

// ===== hdl/fppi_guard.sv
// Write guard that merges hardware protect pins with register locks
`timescale 1ns/1ps
module fppi_guard (
  // Request
  input  wire logic [fppi_pkg::BLK_W-1:0] blk,
  input  wire logic                       dens_8m,
  // Protection sources
  input  wire logic                       top_guard_n,
  input  wire logic                       gen_guard_n,
  input  wire logic [fppi_pkg::NBLK-1:0]  lock_bits,
  // Result
  output logic                            allow
);

  logic is_top;  // Target is the highest block
  logic hw_ok;   // Applicable pin does not protect
  logic in_rng;  // Block exists in this density

  // ****************************************************************
  // Permission decode
  // ****************************************************************
  always_comb begin
    is_top = dens_8m ? (blk == fppi_pkg::TOP_BLK_8M) : (blk == fppi_pkg::TOP_BLK_4M);
    in_rng = dens_8m | (blk <= fppi_pkg::TOP_BLK_4M);
    // Top pin guards only the top block, general pin the rest
    hw_ok  = is_top ? top_guard_n : gen_guard_n;
    // Pins gate only; lock bits are read, never changed here
    allow  = in_rng & hw_ok & ~lock_bits[blk];
  end

endmodule

// ===== hdl/fppi_top.sv
// Pin, strap and write-protect front of a dual-interface flash device
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module fppi_top (
  // Clock and resets
  input  wire logic                          CLOCK,
  input  wire logic                          RST_N,
  input  wire logic                          IFACE_RST_N,
  input  wire logic                          CPU_RST_N,
  // Straps and board inputs
  input  wire logic                          IFACE_SELECT,
  input  wire logic                          DENS_8M,
  input  wire logic [fppi_pkg::ID_W-1:0]     STRAP_IDENTITY,
  input  wire logic [fppi_pkg::GPI_W-1:0]    BOARD_GP_INPUTS,
  // Protect pins
  input  wire logic                          TOP_GUARD_N,
  input  wire logic                          GEN_GUARD_N,
  // Multiplexed interface pins
  input  wire fppi_pkg::fppi_mux_s           MUX_PINS,
  input  wire logic [fppi_pkg::DATA_W-1:0]   DQ_IN,
  output logic      [fppi_pkg::DATA_W-1:0]   DQ_OUT,
  output logic                               DQ_OE,
  output logic                               DONE_INDICATOR,
  // Hub nibble pins
  output logic                               HUB_NIBBLE_IO_OE,
  // Target identity seen on the hub bus
  input  wire logic [fppi_pkg::ID_W-1:0]     HUB_TARGET_ID,
  output logic                               ID_MATCH,
  // Register port
  input  wire logic [3:0]                    REG_ADDR,
  input  wire logic [15:0]                   REG_WDATA,
  input  wire logic                          REG_WR,
  input  wire logic                          REG_RD,
  output logic      [15:0]                   REG_RDATA,
  // Alter outcome
  output logic                               ALTER_GO,
  output logic                               ALTER_DENY
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    fppi_pkg::fppi_op_e               op;        // Alter sequencer
    logic [fppi_pkg::BLK_W-1:0]       blk;       // Block under alteration
    logic [fppi_pkg::NBLK-1:0]        lock;      // Write lock bits
    logic [fppi_pkg::DATA_W-1:0]      status;    // Status byte
    logic [fppi_pkg::ROW_W-1:0]       row;       // Row half latch
    logic [fppi_pkg::COL_W-1:0]       col;       // Column half latch
    logic [fppi_pkg::ADDR_W-1:0]      wr_addr;   // Address of last write
    logic [fppi_pkg::DATA_W-1:0]      wr_data;   // Data of last write
    logic                             wr_n_prev; // Strobe one cycle ago
    logic                             wr_seen;   // A strobed write arrived
    logic                             mux_mode;  // Interface chosen at reset
    logic                             sel_taken; // Select taken after reset
    logic [fppi_pkg::DATA_W-1:0]      dq_out;    // Read drive value
    logic                             dq_oe;     // Data pins driven
    logic                             ready;     // Ready pin
    logic                             hub_oe;    // Hub nibble drive
    logic                             id_match;  // Identity match
    logic [15:0]                      rdata;     // Register read data
    logic                             go;        // Alter granted pulse
    logic                             deny;      // Alter refused pulse
  } fppi_state_s;

  fppi_state_s s_q;  // Registered state
  fppi_state_s s_d;  // Next state

  logic      rst_n;     // Combined internal reset
  logic      allow;     // Guard verdict for the request block
  logic [fppi_pkg::BLK_W-1:0] req_blk;  // Block of a register request
  logic      req_wr;    // Request strobe
  logic      done_wr;   // Finish strobe
  logic      rise;      // Write strobe rising edge

  // ****************************************************************
  // Reset combination
  // ****************************************************************
  // Any of the three inputs low resets the whole block
  assign rst_n = RST_N & IFACE_RST_N & CPU_RST_N;

  // ****************************************************************
  // Register strobes
  // ****************************************************************
  // Request and finish strobes decode the register port
  assign req_wr  = REG_WR & (REG_ADDR == fppi_pkg::OFS_REQ);
  assign done_wr = REG_WR & (REG_ADDR == fppi_pkg::OFS_DONE);
  assign req_blk = REG_WDATA[fppi_pkg::BLK_W-1:0];
  // Strobe level is sampled, so a rise shows one edge after the pin rises
  assign rise    = s_q.mux_mode & ~s_q.wr_n_prev & MUX_PINS.wr_n;

  // ****************************************************************
  // Protection guard
  // ****************************************************************
  fppi_guard u_guard (
    .blk         (req_blk),
    .dens_8m     (DENS_8M),
    .top_guard_n (TOP_GUARD_N),
    .gen_guard_n (GEN_GUARD_N),
    .lock_bits   (s_q.lock),
    .allow       (allow)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    // Hold all state, then let pulses and read data fall back to idle
    s_d      = s_q;
    s_d.go   = 1'b0;
    s_d.deny = 1'b0;
    s_d.rdata = 16'h0000;
    s_d.wr_n_prev = MUX_PINS.wr_n;

    // Interface choice is taken on the first edge after reset, then held
    s_d.sel_taken = 1'b1;
    if (!s_q.sel_taken) begin
      s_d.mux_mode = IFACE_SELECT;
    end

    // Strobe rise latches both address halves and the data byte
    if (rise) begin
      s_d.wr_addr = {s_q.col, s_q.row};
      s_d.wr_data = DQ_IN;
      s_d.wr_seen = 1'b1;
    end
    // Row or column half follows the select while in mux mode
    if (s_q.mux_mode) begin
      if (MUX_PINS.row_sel) begin
        s_d.row = MUX_PINS.addr;
      end else begin
        s_d.col = MUX_PINS.addr[fppi_pkg::COL_W-1:0];
      end
    end

    // Register writes
    if (REG_WR) begin
      case (REG_ADDR)
        fppi_pkg::OFS_LOCK: begin
          s_d.lock = REG_WDATA;  // Only software touches lock bits
        end
        fppi_pkg::OFS_MUX: begin
          s_d.wr_seen = rise;  // A strobe rise in the same cycle wins
        end
        default: begin
        end
      endcase
    end

    // Alter sequencer
    case (s_q.op)
      fppi_pkg::FPPI_IDLE: begin
        if (req_wr) begin
          if (allow) begin
            // Grant starts the alter and shows busy
            s_d.op  = fppi_pkg::FPPI_BUSY;
            s_d.blk = req_blk;
            s_d.go  = 1'b1;
            s_d.status[fppi_pkg::STAT_READY] = 1'b0;
          end else begin
            // Refusal leaves the sequencer idle and flags the status byte
            s_d.deny = 1'b1;
            s_d.status[fppi_pkg::STAT_READY] = 1'b1;
            s_d.status[fppi_pkg::STAT_DENY] = 1'b1;
          end
        end
      end
      fppi_pkg::FPPI_BUSY: begin
        if (done_wr) begin
          // Finish write ends the alter and shows ready
          s_d.op = fppi_pkg::FPPI_IDLE;
          s_d.status[fppi_pkg::STAT_READY] = 1'b1;
        end
      end
      default: begin
        s_d.op = fppi_pkg::FPPI_IDLE;
      end
    endcase

    // Register reads, data stand one cycle later
    // Unmapped offsets answer zero
    if (REG_RD) begin
      case (REG_ADDR)
        fppi_pkg::OFS_IDENT:  s_d.rdata = {12'h000, STRAP_IDENTITY};
        fppi_pkg::OFS_GPI:    s_d.rdata = {11'h000, BOARD_GP_INPUTS};
        fppi_pkg::OFS_LOCK:   s_d.rdata = s_q.lock;
        fppi_pkg::OFS_STATUS: s_d.rdata = {8'h00, s_q.status};
        fppi_pkg::OFS_MUX:    s_d.rdata = {s_q.wr_seen, 3'h0, s_q.wr_addr[fppi_pkg::ADDR_W-1:8]};
        fppi_pkg::OFS_MUXD:   s_d.rdata = {s_q.wr_addr[7:0], s_q.wr_data};
        default:              s_d.rdata = 16'h0000;
      endcase
    end

    // Data pins drive only on a gated read in mux mode, else float
    // Drive is registered, so it follows the gate one edge late
    s_d.dq_oe  = s_q.mux_mode & ~MUX_PINS.oe_n & MUX_PINS.wr_n;
    s_d.dq_out = s_q.status;
    s_d.ready  = s_q.mux_mode & s_q.status[fppi_pkg::STAT_READY];
    s_d.hub_oe = 1'b0;
    s_d.id_match = ~s_q.mux_mode & (HUB_TARGET_ID == STRAP_IDENTITY);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset restores locked blocks and a ready status
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.op        <= fppi_pkg::FPPI_IDLE;
      s_q.lock      <= fppi_pkg::LOCK_RST;
      s_q.status    <= fppi_pkg::STAT_RST;
      s_q.wr_n_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign DQ_OUT           = s_q.dq_out;
  assign DQ_OE            = s_q.dq_oe;
  assign DONE_INDICATOR   = s_q.ready;
  assign HUB_NIBBLE_IO_OE = s_q.hub_oe;
  assign ID_MATCH         = s_q.id_match;
  assign REG_RDATA        = s_q.rdata;
  assign ALTER_GO         = s_q.go;
  assign ALTER_DENY       = s_q.deny;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_TOP_GUARD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && !TOP_GUARD_N && DENS_8M && req_blk == fppi_pkg::TOP_BLK_8M)
    |=> !ALTER_GO && ALTER_DENY)
    else $error("top block altered while top pin low");

  AST_GEN_GUARD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && !GEN_GUARD_N && DENS_8M && req_blk != fppi_pkg::TOP_BLK_8M)
    |=> !ALTER_GO)
    else $error("lower block altered while general pin low");

  AST_LOCK_HOLD: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && s_q.lock[req_blk]) |=> !ALTER_GO)
    else $error("locked block altered");

  AST_PINS_KEEP_LOCK: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !(REG_WR && REG_ADDR == fppi_pkg::OFS_LOCK) |=> $stable(s_q.lock))
    else $error("lock bits changed without software write");

  AST_GRANT: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && TOP_GUARD_N && DENS_8M &&
     req_blk == fppi_pkg::TOP_BLK_8M && !s_q.lock[req_blk]) |=> ALTER_GO ##1 !DONE_INDICATOR)
    else $error("unprotected top block not granted");

  AST_READY: assert property (@(posedge CLOCK) disable iff (!rst_n)
    ##1 DONE_INDICATOR == ($past(s_q.mux_mode) && $past(s_q.status[fppi_pkg::STAT_READY])))
    else $error("ready pin does not mirror status");

  AST_DQ_GATE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    MUX_PINS.oe_n |=> !DQ_OE)
    else $error("data driven without output gate");

  AST_LATCH: assert property (@(posedge CLOCK) disable iff (!rst_n)
    rise |=> s_q.wr_data == $past(DQ_IN) && s_q.wr_seen)
    else $error("strobe rise did not latch data");

  AST_GPI: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (REG_RD && REG_ADDR == fppi_pkg::OFS_GPI) |=> REG_RDATA[4:0] == $past(BOARD_GP_INPUTS))
    else $error("board inputs misread");

  AST_HUB_FLOAT: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !HUB_NIBBLE_IO_OE)
    else $error("hub pins driven");

  // Row half follows the pins in mux mode whenever the select points at the row
  AST_ROW_LATCH: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (s_q.mux_mode && MUX_PINS.row_sel) |=> s_q.row == $past(MUX_PINS.addr))
    else $error("row half not latched");

  // Column half takes the low pins in mux mode while the select points at the column
  AST_COL_LATCH: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (s_q.mux_mode && !MUX_PINS.row_sel) |=> s_q.col == $past(MUX_PINS.addr[fppi_pkg::COL_W-1:0]))
    else $error("column half not latched");

  // Identity compare answers only in hub mode, once the select is taken
  AST_ID_MATCH: assert property (@(posedge CLOCK) disable iff (!rst_n)
    s_q.sel_taken |=> ID_MATCH == (!$past(s_q.mux_mode) && $past(HUB_TARGET_ID) == $past(STRAP_IDENTITY)))
    else $error("identity match wrong");

  // Lower blocks of the small part are guarded by the general pin as well
  AST_GEN_GUARD_4M: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && !GEN_GUARD_N && !DENS_8M && req_blk < fppi_pkg::TOP_BLK_4M)
    |=> !ALTER_GO && ALTER_DENY)
    else $error("lower block of small part altered while general pin low");

  // Top block of the small part is block seven, not fifteen
  AST_TOP_GUARD_4M: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_IDLE && !TOP_GUARD_N && !DENS_8M && req_blk == fppi_pkg::TOP_BLK_4M)
    |=> !ALTER_GO && ALTER_DENY)
    else $error("top block of small part altered while top pin low");

  // A request during an alter is dropped, neither granted nor refused
  AST_BUSY_IGNORE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    (req_wr && s_q.op == fppi_pkg::FPPI_BUSY) |=> !ALTER_GO && !ALTER_DENY)
    else $error("request during alter answered");

  // Every refusal leaves its mark in the status byte
  AST_DENY_FLAG: assert property (@(posedge CLOCK) disable iff (!rst_n)
    ALTER_DENY |-> s_q.status[fppi_pkg::STAT_DENY])
    else $error("refusal not flagged in status");

  // Read data stand only in the cycle after a read
  AST_RDATA_IDLE: assert property (@(posedge CLOCK) disable iff (!rst_n)
    !REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside read answer");

endmodule

// ===== bench/fppi_prog_model.sv
// Behavioural programmer that drives the multiplexed pins of the flash front
`timescale 1ns/1ps
module fppi_prog_model (
  // Clock
  input  wire logic                        clk,
  // Requests from the bench
  input  wire logic                        wr_go,
  input  wire logic [fppi_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [fppi_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        gate_req,
  // Pins toward the device
  output fppi_pkg::fppi_mux_s              mux_pins,
  output logic      [fppi_pkg::DATA_W-1:0] dq_in,
  output logic                             busy
);
  // ****************************************************************
  // Write cycle sequencer
  // ****************************************************************
  logic [2:0] step_q;  // Phase of the write cycle, 0 is idle

  // Idle pins at time zero
  initial begin
    step_q   = 3'h0;
    mux_pins = '{addr: 11'h2aa, row_sel: 1'b1, wr_n: 1'b1, oe_n: 1'b1};
    dq_in    = 8'h3c;
  end

  assign busy = (step_q != 3'h0);

  // Row, then column, strobe low two cycles, hold two cycles past the rise
  always @(posedge clk) begin
    mux_pins.oe_n <= ~gate_req;
    step_q        <= (step_q == 3'h0) ? {2'h0, wr_go} : ((step_q == 3'h6) ? 3'h0 : step_q + 3'h1);
    case (step_q)
      3'h0: begin
        // Released pins change every cycle so stale values never pass
        mux_pins.addr <= wr_go ? wr_addr[10:0] : ~mux_pins.addr;
        dq_in         <= ~dq_in;
      end
      3'h1: begin
        mux_pins.row_sel <= 1'b0;
        mux_pins.addr    <= {2'h0, wr_addr[19:11]};
      end
      3'h2: begin
        mux_pins.wr_n <= 1'b0;
        dq_in         <= wr_data;
      end
      3'h4: mux_pins.wr_n <= 1'b1;
      3'h6: mux_pins.row_sel <= 1'b1;
      default: ;
    endcase
  end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the flash pin, strap and write-protect front
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                CLOCK = 1'b0, RST_N = 1'b0, IFACE_RST_N = 1'b1, CPU_RST_N = 1'b1;
  logic                IFACE_SELECT = 1'b0, DENS_8M = 1'b0, TOP_GUARD_N = 1'b1, GEN_GUARD_N = 1'b1;
  logic [3:0]          STRAP_IDENTITY = 4'h0, HUB_TARGET_ID = 4'h0, REG_ADDR = 4'h0;
  logic [4:0]          BOARD_GP_INPUTS = 5'h00;
  logic [15:0]         REG_WDATA = 16'h0000;
  logic                REG_WR = 1'b0, REG_RD = 1'b0, wr_go = 1'b0, gate_req = 1'b0;
  logic [19:0]         wr_addr = 20'h00000;
  logic [7:0]          wr_data = 8'h00;
  fppi_pkg::fppi_mux_s mux_pins;
  logic [7:0]          dq_in, DQ_OUT;
  logic                DQ_OE, DONE_INDICATOR, HUB_NIBBLE_IO_OE, ID_MATCH, ALTER_GO, ALTER_DENY, busy;
  logic [15:0]         REG_RDATA;
  int                  mismatches = 0;
  int                  n_compared = 0;

  // 125 MHz clock, also standing in for the hub bus clock
  always #4 CLOCK = ~CLOCK;

  // ****************************************************************
  // Device and programmer
  // ****************************************************************
  fppi_top dut_u (
    .CLOCK(CLOCK), .RST_N(RST_N), .IFACE_RST_N(IFACE_RST_N), .CPU_RST_N(CPU_RST_N),
    .IFACE_SELECT(IFACE_SELECT), .DENS_8M(DENS_8M), .STRAP_IDENTITY(STRAP_IDENTITY),
    .BOARD_GP_INPUTS(BOARD_GP_INPUTS), .TOP_GUARD_N(TOP_GUARD_N), .GEN_GUARD_N(GEN_GUARD_N),
    .MUX_PINS(mux_pins), .DQ_IN(dq_in), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
    .DONE_INDICATOR(DONE_INDICATOR), .HUB_NIBBLE_IO_OE(HUB_NIBBLE_IO_OE),
    .HUB_TARGET_ID(HUB_TARGET_ID), .ID_MATCH(ID_MATCH), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ALTER_GO(ALTER_GO), .ALTER_DENY(ALTER_DENY)
  );
  fppi_prog_model model_u (
    .clk(CLOCK), .wr_go(wr_go), .wr_addr(wr_addr), .wr_data(wr_data), .gate_req(gate_req),
    .mux_pins(mux_pins), .dq_in(dq_in), .busy(busy)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Wait edges, then step just past the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  // Compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle register write; strobe drops at the sampling edge so calls may follow back to back
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CLOCK);
    REG_WR    <= 1'b0;
    #1;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLOCK);
    REG_RD   <= 1'b0;
    #1;
    check(what, exp, REG_RDATA);
  endtask

  // Full write cycle on the multiplexed pins
  task automatic mux_write(input logic [19:0] a, input logic [7:0] d);
    int n;
    wr_addr <= a;
    wr_data <= d;
    wr_go   <= 1'b1;
    cyc(1);
    wr_go   <= 1'b0;
    n = 0;
    while (busy && n < 20) begin
      cyc(1);
      n++;
    end
    check("programmer idle", 16'h0, {15'h0, busy});
    cyc(2);
  endtask

  // Counts, verdict and end of run
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic        ok;
    logic [3:0]  top, blk;
    logic [15:0] lockv;
    logic [19:0] mad [2];
    cyc(10);
    check("hub drive in reset", 16'h0, {15'h0, HUB_NIBBLE_IO_OE});
    check("data drive in reset", 16'h0, {15'h0, DQ_OE});
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    cyc(1);
    // Reset contents in hub mode
    rd_chk("lock reset", fppi_pkg::OFS_LOCK, fppi_pkg::LOCK_RST);
    rd_chk("status reset", fppi_pkg::OFS_STATUS, 16'h0080);
    check("ready pin in hub mode", 16'h0, {15'h0, DONE_INDICATOR});
    rd_chk("unmapped", 4'h8, 16'h0000);
    // Identity straps, boot part first, then counting upward
    for (int i = 0; i < 3; i++) begin
      STRAP_IDENTITY <= i[3:0];
      HUB_TARGET_ID  <= i[3:0];
      reg_wr(fppi_pkg::OFS_IDENT, 16'hffff);
      cyc(1);
      rd_chk("identity", fppi_pkg::OFS_IDENT, {12'h0, i[3:0]});
      check("own identity", 16'h1, {15'h0, ID_MATCH});
      HUB_TARGET_ID <= i[3:0] + 4'h1;
      cyc(2);
      check("other identity", 16'h0, {15'h0, ID_MATCH});
    end
    // Board inputs, held steady around each read
    foreach (mad[k]) begin
      BOARD_GP_INPUTS <= k ? 5'h0a : 5'h15;
      cyc(1);
      rd_chk("board inputs", fppi_pkg::OFS_GPI, k ? 16'h000a : 16'h0015);
    end
    // Protect pins against lock bits, top and next-lower block, both densities
    for (int p = 0; p < 32; p++) begin
      top   = p[4] ? fppi_pkg::TOP_BLK_8M : fppi_pkg::TOP_BLK_4M;
      blk   = p[3] ? top : top - 4'h1;
      lockv = p[2] ? (16'h0001 << blk) : 16'h0000;
      ok    = (p[3] ? p[0] : p[1]) & ~p[2];
      DENS_8M     <= p[4];
      TOP_GUARD_N <= p[0];
      GEN_GUARD_N <= p[1];
      reg_wr(fppi_pkg::OFS_LOCK, lockv);
      rd_chk("lock bits", fppi_pkg::OFS_LOCK, lockv);
      reg_wr(fppi_pkg::OFS_REQ, {12'h0, blk});
      check("grant", {15'h0, ok}, {15'h0, ALTER_GO});
      check("refusal", {15'h0, ~ok}, {15'h0, ALTER_DENY});
      if (p == 27) begin
        // A second request while busy is ignored
        reg_wr(fppi_pkg::OFS_REQ, {12'h0, blk});
        check("busy request", 16'h0, {14'h0, ALTER_GO, ALTER_DENY});
      end
      reg_wr(fppi_pkg::OFS_DONE, 16'h0000);
    end
    // Either reset input restores the locks and floats the hub pins
    for (int r = 0; r < 2; r++) begin
      reg_wr(fppi_pkg::OFS_LOCK, 16'h0000);
      if (r == 0) CPU_RST_N <= 1'b0;
      else IFACE_RST_N <= 1'b0;
      cyc(2);
      check("hub drive in reset", 16'h0, {15'h0, HUB_NIBBLE_IO_OE});
      CPU_RST_N   <= 1'b1;
      IFACE_RST_N <= 1'b1;
      cyc(1);
      rd_chk("lock after reset", fppi_pkg::OFS_LOCK, fppi_pkg::LOCK_RST);
    end
    // Multiplexed mode, taken on the first edge after reset
    RST_N        <= 1'b0;
    IFACE_SELECT <= 1'b1;
    cyc(3);
    RST_N <= 1'b1;
    cyc(2);
    check("ready pin idle", 16'h1, {15'h0, DONE_INDICATOR});
    check("data idle", 16'h0, {15'h0, DQ_OE});
    gate_req <= 1'b1;
    cyc(3);
    check("data gated on", 16'h1, {15'h0, DQ_OE});
    check("status on pins", 16'h0080, {8'h0, DQ_OUT});
    gate_req <= 1'b0;
    cyc(3);
    check("data gated off", 16'h0, {15'h0, DQ_OE});
    // Address halves and data captured at the strobe rise
    mad[0] = 20'habcde;
    mad[1] = 20'h7f801;
    foreach (mad[k]) begin
      mux_write(mad[k], k ? 8'ha5 : 8'h5a);
      rd_chk("mux address", fppi_pkg::OFS_MUX, {4'h8, mad[k][19:8]});
      rd_chk("mux data", fppi_pkg::OFS_MUXD, {mad[k][7:0], k ? 8'ha5 : 8'h5a});
      reg_wr(fppi_pkg::OFS_MUX, 16'h0000);
      rd_chk("write seen cleared", fppi_pkg::OFS_MUX, {4'h0, mad[k][19:8]});
    end
    // Ready pin follows the status ready bit through an alter
    reg_wr(fppi_pkg::OFS_LOCK, 16'h0000);
    reg_wr(fppi_pkg::OFS_REQ, 16'h0000);
    check("grant", 16'h1, {15'h0, ALTER_GO});
    cyc(1);
    check("ready pin busy", 16'h0, {15'h0, DONE_INDICATOR});
    rd_chk("status busy", fppi_pkg::OFS_STATUS, 16'h0000);
    reg_wr(fppi_pkg::OFS_DONE, 16'h0000);
    cyc(1);
    check("ready pin done", 16'h1, {15'h0, DONE_INDICATOR});
    close_out();
  end
endmodule
